// file: verilog/xfer_addr_pkg.sv
// Shared constants and carrier types for the transfer address ring pointer block
package xfer_addr_pkg;

    // APB byte offsets of the registers
    localparam logic [7:0] OFS_UPPER_ADDR  = 8'h00;  // shared_upper_addr
    localparam logic [7:0] OFS_CHAN_A_LOW  = 8'h04;  // chan_a_low_addr
    localparam logic [7:0] OFS_CHAN_B_LOW  = 8'h08;  // chan_b_low_addr
    localparam logic [7:0] OFS_CHAN_C_LOW  = 8'h0c;  // chan_c_low_addr
    localparam logic [7:0] OFS_CHAN_B_RLD  = 8'h10;  // chan_b_reload (read only)
    localparam logic [7:0] OFS_RING_CMP    = 8'h14;  // ring_compare_ptr
    localparam logic [7:0] OFS_RING_CTRL   = 8'h18;  // ring_channel_control
    localparam logic [7:0] OFS_BOUNDARY    = 8'h1c;  // boundary_select A/B/C
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h20;  // sticky events, write 1 to clear
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h24;  // interrupt enables

    // Ring channel control bit positions
    localparam int CTRL_RING_BIT   = 7;
    localparam int CTRL_FLAG_BIT   = 6;
    localparam int CTRL_IRQEN_BIT  = 5;
    localparam int CTRL_LOAD_BIT   = 4;
    localparam int CTRL_MARK_BIT   = 3;
    localparam int CTRL_FIXED_BIT  = 2;
    localparam int CTRL_CLKSEL_HI  = 1;
    localparam int CTRL_CLKSEL_LO  = 0;
    localparam logic [7:0] CTRL_RESET_VAL = 8'h1c;

    // Boundary select field layout, three bits per channel
    localparam int BND_W      = 3;
    localparam int BND_A_LSB  = 0;
    localparam int BND_B_LSB  = 3;
    localparam int BND_C_LSB  = 6;
    localparam logic [8:0] BND_RESET_VAL = 9'h1ff;

    // Interrupt status bit positions
    localparam int IRQ_W        = 4;
    localparam int IRQ_OVF_A    = 0;
    localparam int IRQ_OVF_B    = 1;
    localparam int IRQ_OVF_C    = 2;
    localparam int IRQ_OVERRUN  = 3;

    // Channel numbers
    localparam int NUM_CHAN = 3;
    localparam logic [1:0] CHAN_A = 2'h0;
    localparam logic [1:0] CHAN_B = 2'h1;
    localparam logic [1:0] CHAN_C = 2'h2;

    // Transfer request carrier from the transfer control logic
    typedef struct packed {
        logic [2:0] step;        // One pulse per transferred unit, per channel
        logic [1:0] active_chan; // Channel whose address is driven
        logic       pbi_mode;    // Parallel-port bound buffer mode
        logic       master_rd;   // Master CPU read transfer (channel A)
        logic       master_wr;   // Master CPU write transfer (channel B)
    } xfer_req_s;

    // Address selection result
    typedef enum logic [1:0] {
        SRC_A,
        SRC_B,
        SRC_C
    } addr_src_e;

endpackage : xfer_addr_pkg

// file: verilog/low_addr_counter.sv
// Lower address counter with reload register and boundary-limited carry
`timescale 1ns/10ps
`default_nettype none

module low_addr_counter #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    // Control
    input  wire logic         i_wr_en,    // Software write of the address
    input  wire logic [W-1:0] i_wr_data,
    input  wire logic         i_load,     // Reload value into address
    input  wire logic         i_mark,     // Address into reload value
    input  wire logic         i_step,     // One unit transferred
    input  wire logic [W-1:0] i_mask,     // Ones below the boundary
    // State
    output logic      [W-1:0] o_addr,
    output logic      [W-1:0] o_reload,
    output logic              o_ovf       // Boundary carry this cycle
);

    logic [W-1:0] addr_q;     // Counter
    logic [W-1:0] reload_q;   // Starting value
    logic [W-1:0] inc_low;    // Incremented low part
    logic [W-1:0] step_d;     // Value after a step

    // Carry out of the field below the boundary
    assign o_ovf   = i_step & ((addr_q & i_mask) == i_mask);
    assign inc_low = (addr_q + {{(W-1){1'b0}}, 1'b1}) & i_mask;
    // Keep bits above, restore bits below from reload on carry
    assign step_d  = o_ovf ? ((addr_q & ~i_mask) | (reload_q & i_mask))
                           : ((addr_q & ~i_mask) | inc_low);

    // Address counter; software write wins over load and step
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_q <= '0;
        end else if (i_ce) begin
            if (i_wr_en) begin
                addr_q <= i_wr_data;
            end else if (i_load) begin
                addr_q <= reload_q;
            end else if (i_step) begin
                addr_q <= step_d;
            end
        end
    end

    // Reload register follows software writes, or marks the pointer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reload_q <= '0;
        end else if (i_ce) begin
            if (i_wr_en) begin
                reload_q <= i_wr_data;
            end else if (i_mark) begin
                reload_q <= addr_q;
            end
        end
    end

    assign o_addr   = addr_q;
    assign o_reload = reload_q;

endmodule // low_addr_counter

`default_nettype wire

// file: verilog/ring_overrun_flag.sv
// Ring buffer overrun detection and flag with read-then-write-zero clear
`timescale 1ns/10ps
`default_nettype none

module ring_overrun_flag #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    // Pointer state
    input  wire logic         i_ring_active,
    input  wire logic         i_step_b,     // Channel B advanced this cycle
    input  wire logic [W-1:0] i_addr_b,
    input  wire logic [W-1:0] i_cmp,
    // Software access to the control register
    input  wire logic         i_ctrl_rd,    // Completed read
    input  wire logic         i_ctrl_wr,    // Completed write
    input  wire logic         i_wr_flag,    // Written flag bit value
    // Result
    output logic              o_flag,
    output logic              o_set         // Pulse when flag gets set
);

    logic stepped_q;  // Channel B moved in the previous cycle
    logic armed_q;    // Flag was read as one
    logic flag_q;     // Overrun flag
    logic clear;      // Qualified clear

    // Compare after the increment has landed in the counter
    assign o_set = stepped_q & i_ring_active & (i_addr_b == i_cmp);
    assign clear = i_ctrl_wr & ~i_wr_flag & armed_q;

    // Remember a step for one cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stepped_q <= 1'b0;
        end else if (i_ce) begin
            stepped_q <= i_step_b;
        end
    end

    // Arm on a read that saw the flag set; a write consumes it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            armed_q <= 1'b0;
        end else if (i_ce) begin
            if (i_ctrl_rd) begin
                armed_q <= flag_q;
            end else if (i_ctrl_wr) begin
                armed_q <= 1'b0;
            end
        end
    end

    // Flag: set wins over clear, writing one does nothing
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flag_q <= 1'b0;
        end else if (i_ce) begin
            if (o_set) begin
                flag_q <= 1'b1;
            end else if (clear) begin
                flag_q <= 1'b0;
            end
        end
    end

    assign o_flag = flag_q;

endmodule // ring_overrun_flag

`default_nettype wire

// file: verilog/transfer_address_ring_pointer.sv
// Transfer address generation with ring pointer, APB registers and interrupts
`timescale 1ns/10ps
`default_nettype none

module transfer_address_ring_pointer #(
    parameter int AW = 8,  // Width of each address byte
    parameter int PW = 8   // APB address width
) (
    // Clock, reset and enable
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_ce,
    // APB slave
    input  wire logic                   i_psel,
    input  wire logic                   i_penable,
    input  wire logic                   i_pwrite,
    input  wire logic [PW-1:0]          i_paddr,
    input  wire logic [31:0]            i_pwdata,
    input  wire logic [3:0]             i_pstrb,
    output logic      [31:0]            o_prdata,
    output logic                        o_pready,
    output logic                        o_pslverr,
    // Transfer side
    input  wire xfer_addr_pkg::xfer_req_s i_xfer,
    input  wire logic                   i_chan_b_repeat_enable,
    output logic      [2*AW-1:0]        o_ram_addr,
    output logic      [1:0]             o_timer_clk_sel,
    // Interrupts
    output logic                        o_overrun_irq,
    output logic                        o_irq
);
    import xfer_addr_pkg::*;

    // Register state
    // Load and mark are strobes, so they have no storage here
    logic [AW-1:0]     upper_q;       // Shared upper address byte
    logic [AW-1:0]     cmp_q;         // Ring compare pointer
    logic              ring_q;        // Ring mode bit
    logic              irqen_q;       // Overrun interrupt enable
    logic [1:0]        clksel_q;      // Timer clock select bits
    logic [3*BND_W-1:0] bnd_q;        // Boundary selects A/B/C
    logic [IRQ_W-1:0]  status_q;      // Sticky event bits
    logic [IRQ_W-1:0]  mask_q;        // Event enables
    logic [2*AW-1:0]   ram_addr_q;    // Registered transfer address
    logic [31:0]       prdata_q;      // Registered read data
    logic              seen_q;        // Setup phase seen

    // Channel counters
    // Indexed 0, 1, 2 for channels A, B, C
    logic [AW-1:0] addr   [NUM_CHAN];
    logic [AW-1:0] reload [NUM_CHAN];
    logic [AW-1:0] mask   [NUM_CHAN];
    logic [NUM_CHAN-1:0] step;
    logic [NUM_CHAN-1:0] ovf;
    logic [NUM_CHAN-1:0] wr_low;

    // Bus decode
    // One-hot hits of the register offsets
    logic        acc_done;   // Access completes this cycle
    logic        wr_done;
    logic        rd_done;
    logic        lane0;
    logic [7:0]  wdat;
    logic        hit_upper;
    logic        hit_a;
    logic        hit_b;
    logic        hit_c;
    logic        hit_rld;
    logic        hit_cmp;
    logic        hit_ctrl;
    logic        hit_bnd;
    logic        hit_stat;
    logic        hit_mask;
    logic        mapped;
    logic [31:0] rd_mux;
    logic [7:0]  ctrl_rd;

    // Ring and flag
    // Ring mode gating and overrun flag state
    logic        ring_active;
    logic        load_b;
    logic        mark_b;
    logic        flag;
    logic        flag_set;
    addr_src_e   src;
    logic [IRQ_W-1:0] events;

    // Access phase completion
    // Zero wait states; a low clock enable holds ready low so nothing completes
    assign o_pready  = i_ce & i_psel & i_penable & seen_q;
    assign acc_done  = o_pready;
    assign wr_done   = acc_done & i_pwrite;
    assign rd_done   = acc_done & ~i_pwrite;
    assign lane0     = i_pstrb[0];
    assign wdat      = i_pwdata[7:0];

    // Address decode
    // Exact match, so unaligned addresses take the error path
    assign hit_upper = (i_paddr == PW'(OFS_UPPER_ADDR));
    assign hit_a     = (i_paddr == PW'(OFS_CHAN_A_LOW));
    assign hit_b     = (i_paddr == PW'(OFS_CHAN_B_LOW));
    assign hit_c     = (i_paddr == PW'(OFS_CHAN_C_LOW));
    assign hit_rld   = (i_paddr == PW'(OFS_CHAN_B_RLD));
    assign hit_cmp   = (i_paddr == PW'(OFS_RING_CMP));
    assign hit_ctrl  = (i_paddr == PW'(OFS_RING_CTRL));
    assign hit_bnd   = (i_paddr == PW'(OFS_BOUNDARY));
    assign hit_stat  = (i_paddr == PW'(OFS_IRQ_STATUS));
    assign hit_mask  = (i_paddr == PW'(OFS_IRQ_MASK));
    assign mapped    = hit_upper | hit_a | hit_b | hit_c | hit_rld | hit_cmp
                     | hit_ctrl | hit_bnd | hit_stat | hit_mask;
    // Unmapped addresses answer with an error, read zero
    assign o_pslverr = acc_done & ~mapped;

    // The 8-bit registers live in byte lane zero
    // write sets reload
    assign wr_low[0] = wr_done & lane0 & hit_a;
    assign wr_low[1] = wr_done & lane0 & hit_b;
    assign wr_low[2] = wr_done & lane0 & hit_c;

    // Both strobes in one write swap the two pointers
    // zero loads pointer
    assign load_b = wr_done & lane0 & hit_ctrl & ~wdat[CTRL_LOAD_BIT];
    assign mark_b = wr_done & lane0 & hit_ctrl & ~wdat[CTRL_MARK_BIT];

    // Ring bit alone leaves channel B a plain counter
    // ring needs both
    assign ring_active = ring_q & i_chan_b_repeat_enable;

    // Master accesses replace the channel pulses in parallel mode
    // parallel mode steps
    assign step[0] = i_xfer.pbi_mode ? i_xfer.master_rd : i_xfer.step[0];
    assign step[1] = i_xfer.pbi_mode ? i_xfer.master_wr : i_xfer.step[1];
    assign step[2] = ~i_xfer.pbi_mode & i_xfer.step[2];

    // Boundary masks, one more low bit per select step
    // Widened before the shift so select seven gives all eight bits
    // limit carry range
    assign mask[0] = AW'((9'h002 << bnd_q[BND_A_LSB +: BND_W]) - 9'h001);
    assign mask[1] = AW'((9'h002 << bnd_q[BND_B_LSB +: BND_W]) - 9'h001);
    assign mask[2] = AW'((9'h002 << bnd_q[BND_C_LSB +: BND_W]) - 9'h001);

    // One counter per channel
    // Only channel B gets the load and mark strobes
    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            low_addr_counter #(
                .W         (AW)
            ) u_cnt (
                .i_clk     (i_clk),
                .i_rst_n   (i_rst_n),
                .i_ce      (i_ce),
                .i_wr_en   (wr_low[g]),
                .i_wr_data (wdat[AW-1:0]),
                .i_load    ((g == 1) ? load_b : 1'b0),
                .i_mark    ((g == 1) ? mark_b : 1'b0),
                .i_step    (step[g]),
                .i_mask    (mask[g]),
                .o_addr    (addr[g]),
                .o_reload  (reload[g]),
                .o_ovf     (ovf[g])
            );
        end
    endgenerate

    // Overrun flag with its read-then-write-zero clear
    // compare after increment
    ring_overrun_flag #(
        .W             (AW)
    ) u_flag (
        .i_clk         (i_clk),
        .i_rst_n       (i_rst_n),
        .i_ce          (i_ce),
        .i_ring_active (ring_active),
        .i_step_b      (step[1]),
        .i_addr_b      (addr[1]),
        .i_cmp         (cmp_q),
        .i_ctrl_rd     (rd_done & hit_ctrl),
        .i_ctrl_wr     (wr_done & lane0 & hit_ctrl),
        .i_wr_flag     (wdat[CTRL_FLAG_BIT]),
        .o_flag        (flag),
        .o_set         (flag_set)
    );

    // Source of the transfer address
    // In parallel mode master writes use B and all else A; otherwise the active channel
    assign src = i_xfer.pbi_mode ? (i_xfer.master_wr ? SRC_B : SRC_A)
               : (i_xfer.active_chan == CHAN_B) ? SRC_B
               : (i_xfer.active_chan == CHAN_C) ? SRC_C : SRC_A;

    // Control register read image
    // Fixed bit and the strobe positions always read one
    // fixed bit one
    assign ctrl_rd = {ring_q, flag, irqen_q, 1'b1, 1'b1, 1'b1, clksel_q};

    // Read data selection
    // Unmapped offsets read as zero
    assign rd_mux = hit_upper ? {24'h000000, 8'(upper_q)}
                  : hit_a     ? {24'h000000, 8'(addr[0])}
                  : hit_b     ? {24'h000000, 8'(addr[1])}
                  : hit_c     ? {24'h000000, 8'(addr[2])}
                  : hit_rld   ? {24'h000000, 8'(reload[1])}
                  : hit_cmp   ? {24'h000000, 8'(cmp_q)}
                  : hit_ctrl  ? {24'h000000, ctrl_rd}
                  : hit_bnd   ? {23'h000000, bnd_q}
                  : hit_stat  ? {28'h0000000, status_q}
                  : hit_mask  ? {28'h0000000, mask_q}
                  : 32'h00000000;

    // Interrupt events
    // Boundary carries and overrun sets feed the sticky status
    assign events[IRQ_OVF_A]   = ovf[0];
    assign events[IRQ_OVF_B]   = ovf[1];
    assign events[IRQ_OVF_C]   = ovf[2];
    assign events[IRQ_OVERRUN] = flag_set;

    // APB read data and setup tracking
    // Read data is taken in setup and stands through the access cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prdata_q <= 32'h00000000;
            seen_q   <= 1'b0;
        end else if (i_ce) begin
            seen_q <= i_psel & ~acc_done;
            if (i_psel) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // Upper byte and compare pointer
    // Written through byte lane zero only
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            upper_q <= '0;
            cmp_q   <= '0;
        end else if (i_ce && wr_done && lane0) begin
            if (hit_upper) begin
                upper_q <= wdat[AW-1:0];
            end else if (hit_cmp) begin
                cmp_q <= wdat[AW-1:0];
            end
        end
    end

    // Ring control bits
    // reset value
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ring_q   <= CTRL_RESET_VAL[CTRL_RING_BIT];
            irqen_q  <= CTRL_RESET_VAL[CTRL_IRQEN_BIT];
            clksel_q <= CTRL_RESET_VAL[CTRL_CLKSEL_HI:CTRL_CLKSEL_LO];
        end else if (i_ce && wr_done && lane0 && hit_ctrl) begin
            ring_q   <= wdat[CTRL_RING_BIT];
            irqen_q  <= wdat[CTRL_IRQEN_BIT];
            clksel_q <= wdat[CTRL_CLKSEL_HI:CTRL_CLKSEL_LO];
        end
    end

    // Boundary selects and interrupt mask
    // The boundary word spans lanes zero and one
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bnd_q  <= BND_RESET_VAL;
            mask_q <= '0;
        end else if (i_ce && wr_done) begin
            if (hit_bnd && (&i_pstrb[1:0])) begin
                bnd_q <= i_pwdata[3*BND_W-1:0];
            end else if (hit_mask && lane0) begin
                mask_q <= i_pwdata[IRQ_W-1:0];
            end
        end
    end

    // Sticky status: new events win over the write-one clear
    // An event in the cycle of its clear keeps the bit set
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_q <= '0;
        end else if (i_ce) begin
            if (wr_done && lane0 && hit_stat) begin
                status_q <= (status_q & ~i_pwdata[IRQ_W-1:0]) | events;
            end else begin
                status_q <= status_q | events;
            end
        end
    end

    // Transfer address register
    // Registered so the address stands a whole cycle
    // join upper and low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ram_addr_q <= '0;
        end else if (i_ce) begin
            case (src)
                SRC_B: begin
                    ram_addr_q <= {upper_q, addr[1]};
                end
                SRC_C: begin
                    ram_addr_q <= {upper_q, addr[2]};
                end
                default: begin
                    ram_addr_q <= {upper_q, addr[0]};
                end
            endcase
        end
    end

    // Outputs
    // Interrupt outputs are levels built from registers
    assign o_prdata        = prdata_q;
    assign o_ram_addr      = ram_addr_q;
    assign o_timer_clk_sel = clksel_q;
    assign o_overrun_irq   = flag & irqen_q;
    assign o_irq           = |(status_q & mask_q);

endmodule // transfer_address_ring_pointer

`default_nettype wire

// file: test/ring_ptr_properties.sv
// Concurrent checks on the ring pointer block ports
`timescale 1ns/10ps
`default_nettype none
module ring_ptr_properties (
    // Watched ports
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_ce,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0]  i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [15:0] o_ram_addr,
    input wire logic [1:0]  o_timer_clk_sel,
    input wire logic        o_overrun_irq
);
    import xfer_addr_pkg::*;
    // Completed transfers
    wire logic done_rd = i_psel && i_penable && o_pready && !i_pwrite;
    wire logic done_wr = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0];
    wire logic ctrl_rd = done_rd && (i_paddr == OFS_RING_CTRL);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_ZERO_WAIT: assert property (i_ce && i_psel && !i_penable ##1 i_ce && i_psel && i_penable
        |-> o_pready) else $error("access cycle without ready");
    AST_CTRL_FIXED_ONE: assert property (ctrl_rd |-> o_prdata[2])
        else $error("fixed control bit read zero");
    AST_CTRL_STROBES_ONE: assert property (ctrl_rd |-> o_prdata[4:3] == 2'b11)
        else $error("load or mark position read zero");
    AST_IRQ_MATCHES_FLAG: assert property (ctrl_rd |->
        $past(o_overrun_irq) == (o_prdata[6] && o_prdata[5])) else $error("overrun irq wrong");
    AST_UPPER_ADDR_OUT: assert property (done_wr && i_paddr == OFS_UPPER_ADDR |->
        ##2 o_ram_addr[15:8] == $past(i_pwdata[7:0], 2)) else $error("upper byte not driven");
    AST_CLK_SEL_OUT: assert property (done_wr && i_paddr == OFS_RING_CTRL |->
        ##2 o_timer_clk_sel == $past(i_pwdata[1:0], 2)) else $error("clock select not driven");
    AST_UNMAPPED_READ_ZERO: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("unmapped read not zero");
    AST_SLVERR_WITH_READY: assert property (o_pslverr |-> o_pready && i_paddr > OFS_IRQ_MASK)
        else $error("error response out of place");
    AST_READ_HIGH_ZERO: assert property (done_rd |-> o_prdata[31:9] == 23'h0)
        else $error("unused read bits set");
    // Main scenarios reached
    cover property (ctrl_rd && o_prdata[6]);
    cover property (o_overrun_irq);
    cover property (o_pslverr);
endmodule // ring_ptr_properties
bind transfer_address_ring_pointer ring_ptr_properties u_props (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_ram_addr(o_ram_addr), .o_timer_clk_sel(o_timer_clk_sel),
    .o_overrun_irq(o_overrun_irq));
`default_nettype wire

// file: test/xfer_source.sv
// Transfer control stand-in issuing one-cycle step pulses
`timescale 1ns/10ps
`default_nettype none
module xfer_source (
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    // Command from the bench
    input  wire logic                    i_go,
    input  wire logic [1:0]              i_chan,
    input  wire logic                    i_pbi,
    // Request toward the block
    output var  xfer_addr_pkg::xfer_req_s o_xfer
);
    import xfer_addr_pkg::*;
    // One pulse per command; parallel mode turns A/B steps into master accesses
    // channel steps
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_xfer <= '0;
        end else begin
            o_xfer.step        <= (i_go && !i_pbi) ? (3'h1 << i_chan) : 3'h0;
            o_xfer.active_chan <= i_chan;
            o_xfer.pbi_mode    <= i_pbi;
            o_xfer.master_rd   <= i_go && i_pbi && (i_chan == CHAN_A);
            o_xfer.master_wr   <= i_go && i_pbi && (i_chan == CHAN_B);
        end
    end
endmodule // xfer_source
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the transfer address ring pointer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import xfer_addr_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, go = 0, parallel_port_transfer = 0, rep = 0, ce = 1;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdata;
    logic [1:0]  chan = '0, clk_sel;
    logic        pready, pslverr, err, ovr_irq, irq;
    logic [15:0] ram_addr;
    xfer_req_s   xfer;
    int          n_errors = 0, checks = 0;
    // Clock of 8 ns period
    always #4 clk = ~clk;
    xfer_source u_src (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_chan(chan), .i_pbi(parallel_port_transfer),
        .o_xfer(xfer));
    transfer_address_ring_pointer u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_xfer(xfer), .i_chan_b_repeat_enable(rep), .o_ram_addr(ram_addr),
        .o_timer_clk_sel(clk_sel), .o_overrun_irq(ovr_irq), .o_irq(irq));
    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    // One APB transfer, held until ready, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        // Ready is sampled at the rising edge; only the watchdog ends a wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask
    // One transferred unit on a channel
    task automatic step(input logic [1:0] c);
        chan <= c; go <= 1;
        @(posedge clk);
        go <= 0;
        repeat (4) @(posedge clk);
    endtask
    // Report and end the run
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #200000;
        n_errors++;
        give_verdict;
    end
    // Test sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rd(OFS_RING_CTRL, 32'h1c);
        rd(OFS_BOUNDARY, 32'h1ff);
        wr(OFS_RING_CTRL, 32'hff);
        rd(OFS_RING_CTRL, 32'hbf);
        chk(clk_sel, 2'h3);
        // Channel A inside a two-bit boundary
        wr(OFS_UPPER_ADDR, 32'h12);
        wr(OFS_BOUNDARY, 32'h1f9);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_CHAN_A_LOW, 32'h45);
        step(CHAN_A);
        chk(ram_addr, 16'h1246);
        step(CHAN_A);
        step(CHAN_A);
        rd(OFS_CHAN_A_LOW, 32'h45);
        chk(irq, 1'b1);
        wr(OFS_IRQ_STATUS, 32'h1);
        rd(OFS_IRQ_STATUS, 32'h0);
        chk(irq, 1'b0);
        // Mark then load on channel B
        wr(OFS_CHAN_B_LOW, 32'h10);
        step(CHAN_B);
        step(CHAN_B);
        wr(OFS_RING_CTRL, 32'h14);
        rd(OFS_CHAN_B_RLD, 32'h12);
        step(CHAN_B);
        wr(OFS_RING_CTRL, 32'h0c);
        rd(OFS_CHAN_B_LOW, 32'h12);
        // Ring overrun, set and cleared
        rep <= 1;
        wr(OFS_RING_CMP, 32'h13);
        wr(OFS_RING_CTRL, 32'hbc);
        step(CHAN_B);
        rd(OFS_RING_CTRL, 32'hfc);
        chk(ovr_irq, 1'b1);
        wr(OFS_RING_CTRL, 32'hfc);
        rd(OFS_RING_CTRL, 32'hfc);
        wr(OFS_RING_CTRL, 32'hbc);
        rd(OFS_RING_CTRL, 32'hbc);
        chk(ovr_irq, 1'b0);
        // Parallel mode master read advances A
        parallel_port_transfer <= 1;
        step(CHAN_A);
        rd(OFS_CHAN_A_LOW, 32'h46);
        // Clock enable low: the master read pulse is lost
        ce <= 0;
        step(CHAN_A);
        ce <= 1;
        rd(OFS_CHAN_A_LOW, 32'h46);
        rd(8'h40, 32'h0);
        chk(err, 1'b1);
        give_verdict;
    end
endmodule // testbench
`default_nettype wire
